/* sbl_pkg.sv */
// constants, register map and states of the secure boot and otp loader
// assumes one 100 mhz clock, an otp read port whose data is valid while the read strobe is high, and a byte-wise flash reader
package sbl_pkg;
    localparam int CLK_MHZ = 100;
    localparam int RST_DELAY_US = 15;
    localparam int RST_DELAY_CYC = RST_DELAY_US * CLK_MHZ;
    localparam logic [31:0] SKIP_CRC = 32'h0D15_AB1E;
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam int OTP_SECTORS = 4;
    localparam int OTP_ROWS = 512;
    localparam int OTP_AW = 12;
    localparam logic [11:0] OTP_SEC_ROW = 12'h0800;
    localparam logic [11:0] OTP_BOOT_ROW = 12'h0000;
    localparam logic [31:0] RAM_BASE = 32'h0000_0000;
    localparam int SEC_JTAG_DIS = 0;
    localparam int SEC_LINK_DIS = 1;
    localparam int SEC_BOOT_OTP = 5;
    localparam int SEC_REDUND = 7;
    localparam int SEC_LOCK0 = 8;
    localparam int SEC_MASTER = 12;
    localparam int SEC_JTAG_OTP = 13;
    localparam int SEC_GP_LO = 15;
    localparam int SEC_GP_HI = 21;
    localparam int SEC_UID_LO = 22;
    localparam int SEC_UID_HI = 31;
    localparam logic [23:0] REG_SEC = 24'h00_0000;
    localparam logic [23:0] REG_STATUS = 24'h00_0004;
    localparam logic [23:0] REG_PRG_ADDR = 24'h10_0200;
    localparam logic [23:0] REG_PRG_DATA = 24'h20_0100;
    localparam logic [23:0] REG_PRG_CTRL = 24'h10_0300;
    localparam int CTRL_GO = 0;
    localparam int CTRL_CLR = 1;
    localparam logic [31:0] SEC_RESET = 32'h0000_0000;
    typedef enum logic [3:0] {
        ST_HOLD, ST_DELAY, ST_SEC, ST_SECW, ST_REQ, ST_FLW, ST_OTPR, ST_OTPW, ST_OTPB,
        ST_CHECK, ST_RUN, ST_FAIL
    } sbl_state_t;
    typedef enum logic [1:0] {
        PH_SIZE, PH_PROG, PH_CHK
    } sbl_phase_t;
endpackage

/* sbl_loader.sv */
// boot sequencer, image loader, crc checker and security configuration holder
// assumes otp read data valid in the cycle otp_rd is high, flash bytes answered by flash_valid
`timescale 1ns/1ns
module sbl_loader #(
    parameter int RAM_AW = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ext_rst_n,
    input wire logic [23:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    output logic flash_req,
    input wire logic flash_valid,
    input wire logic [7:0] flash_byte,
    output logic otp_rd,
    output logic [11:0] otp_raddr,
    input wire logic [31:0] otp_rdata,
    output logic otp_prog,
    output logic [11:0] otp_paddr,
    output logic [31:0] otp_pdata,
    output logic ram_we,
    output logic [RAM_AW-1:0] ram_addr,
    output logic [31:0] ram_wdata,
    output logic core_rst,
    output logic core_run,
    output logic [31:0] core_pc,
    output logic gpio_pd_en,
    output logic jtag_dis,
    output logic link_dis,
    output logic jtag_otp_dis,
    output logic otp_redund_en,
    output logic [9:0] user_id
);
    if (RAM_AW < 2 || RAM_AW > 30) begin : g_chk
        $error("RAM_AW out of range");
    end

    localparam int DLY_W = $clog2(sbl_pkg::RST_DELAY_CYC + 1);
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(sbl_pkg::RST_DELAY_CYC - 1);

    function automatic logic [31:0] sbl_crc8(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ sbl_pkg::CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    sbl_pkg::sbl_state_t st_r;
    sbl_pkg::sbl_phase_t ph_r;
    logic [DLY_W-1:0] dly_r;
    logic [31:0] sec_r;
    logic sec_valid_r;
    logic [31:0] word_sh_r;
    logic [1:0] bcnt_r;
    logic [31:0] size_r;
    logic [31:0] rem_r;
    logic [31:0] chk_r;
    logic [31:0] crc_r;
    logic [31:0] ob_word_r;
    logic [1:0] ob_cnt_r;
    logic [11:0] otp_ptr_r;
    logic [15:0] prg_addr_r;
    logic [31:0] prg_data_r;
    logic refused_r;
    logic flash_req_r, otp_rd_r, otp_prog_r, ram_we_r, core_rst_r, core_run_r, gpio_pd_en_r;
    logic jtag_dis_r, link_dis_r, jtag_otp_dis_r, otp_redund_en_r;
    logic [11:0] otp_raddr_r, otp_paddr_r;
    logic [31:0] otp_pdata_r, ram_wdata_r, core_pc_r, reg_rdata_r;
    logic [RAM_AW-1:0] ram_addr_r;
    logic [9:0] user_id_r;

    logic got_byte;
    logic [7:0] cur_byte;
    logic [31:0] full_word;
    logic word_done;
    logic image_done;
    logic go_wr;
    logic prg_ok;

    // one byte per cycle from the otp shift word, or the flash answer
    assign got_byte = (st_r == sbl_pkg::ST_FLW && flash_valid) || st_r == sbl_pkg::ST_OTPB;
    assign cur_byte = (st_r == sbl_pkg::ST_OTPB) ? ob_word_r[7:0] : flash_byte;
    assign full_word = {cur_byte, word_sh_r[31:8]};
    assign word_done = got_byte && bcnt_r == 2'd3;
    assign image_done = word_done && ph_r == sbl_pkg::PH_CHK;
    assign go_wr = reg_we && reg_addr == sbl_pkg::REG_PRG_CTRL && reg_wdata[sbl_pkg::CTRL_GO];

    // programming is refused until the security word is known, and by every lock
    always_comb begin
        prg_ok = sec_valid_r && !sec_r[sbl_pkg::SEC_MASTER];
        if (prg_addr_r[11:0] == sbl_pkg::OTP_SEC_ROW && prg_addr_r[15:12] == 4'h0) begin
            prg_ok = prg_ok;
        end else if (prg_addr_r < 16'(sbl_pkg::OTP_SECTORS * sbl_pkg::OTP_ROWS)) begin
            prg_ok = prg_ok && !sec_r[sbl_pkg::SEC_LOCK0 + int'(prg_addr_r[10:9])];
        end else begin
            prg_ok = 1'b0;
        end
    end

    // boot sequencer
    always_ff @(posedge clock) begin
        if (srst || !ext_rst_n) begin
            st_r <= sbl_pkg::ST_HOLD;
        end else begin
            case (st_r)
                sbl_pkg::ST_HOLD: st_r <= sbl_pkg::ST_DELAY;
                sbl_pkg::ST_DELAY: if (dly_r == DLY_LAST) st_r <= sbl_pkg::ST_SEC;
                sbl_pkg::ST_SEC: st_r <= sbl_pkg::ST_SECW;
                sbl_pkg::ST_SECW: st_r <= sbl_pkg::ST_REQ;
                sbl_pkg::ST_REQ: begin
                    if (sec_r[sbl_pkg::SEC_BOOT_OTP]) begin
                        st_r <= sbl_pkg::ST_OTPR;
                    end else begin
                        st_r <= sbl_pkg::ST_FLW;
                    end
                end
                sbl_pkg::ST_FLW: begin
                    if (image_done) begin
                        st_r <= sbl_pkg::ST_CHECK;
                    end else if (flash_valid) begin
                        st_r <= sbl_pkg::ST_REQ;
                    end
                end
                sbl_pkg::ST_OTPR: st_r <= sbl_pkg::ST_OTPW;
                sbl_pkg::ST_OTPW: st_r <= sbl_pkg::ST_OTPB;
                sbl_pkg::ST_OTPB: begin
                    if (image_done) begin
                        st_r <= sbl_pkg::ST_CHECK;
                    end else if (ob_cnt_r == 2'd3) begin
                        st_r <= sbl_pkg::ST_REQ;
                    end
                end
                sbl_pkg::ST_CHECK: begin
                    // skip word or a matching complemented crc lets the program run
                    if (chk_r == sbl_pkg::SKIP_CRC || chk_r == ~crc_r) begin
                        st_r <= sbl_pkg::ST_RUN;
                    end else begin
                        st_r <= sbl_pkg::ST_FAIL;
                    end
                end
                sbl_pkg::ST_RUN: st_r <= sbl_pkg::ST_RUN;
                sbl_pkg::ST_FAIL: st_r <= sbl_pkg::ST_FAIL;
                default: st_r <= sbl_pkg::ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (st_r == sbl_pkg::ST_DELAY) begin
            dly_r <= dly_r + 1'b1;
        end else begin
            dly_r <= '0;
        end
    end

    // security word: loaded from otp, only the general purpose field is software writable
    always_ff @(posedge clock) begin
        if (srst || !ext_rst_n) begin
            sec_r <= sbl_pkg::SEC_RESET;
            sec_valid_r <= 1'b0;
        end else if (st_r == sbl_pkg::ST_SECW) begin
            sec_r <= otp_rdata;
            sec_valid_r <= 1'b1;
        end else if (reg_we && reg_addr == sbl_pkg::REG_SEC && sec_valid_r) begin
            sec_r[sbl_pkg::SEC_GP_HI:sbl_pkg::SEC_GP_LO] <= reg_wdata[sbl_pkg::SEC_GP_HI:sbl_pkg::SEC_GP_LO];
        end
    end

    // byte assembler, phase tracking and crc
    always_ff @(posedge clock) begin
        if (st_r == sbl_pkg::ST_HOLD) begin
            ph_r <= sbl_pkg::PH_SIZE;
            bcnt_r <= 2'd0;
            word_sh_r <= '0;
            size_r <= '0;
            rem_r <= '0;
            chk_r <= '0;
            crc_r <= sbl_pkg::CRC_INIT;
        end else if (got_byte) begin
            word_sh_r <= full_word;
            bcnt_r <= bcnt_r + 2'd1;
            if (ph_r != sbl_pkg::PH_CHK) begin
                crc_r <= sbl_crc8(crc_r, cur_byte);
            end
            if (word_done) begin
                case (ph_r)
                    sbl_pkg::PH_SIZE: begin
                        size_r <= full_word;
                        rem_r <= full_word;
                        ph_r <= (full_word == 32'h0000_0000) ? sbl_pkg::PH_CHK : sbl_pkg::PH_PROG;
                    end
                    sbl_pkg::PH_PROG: begin
                        rem_r <= rem_r - 32'd1;
                        if (rem_r == 32'd1) ph_r <= sbl_pkg::PH_CHK;
                    end
                    sbl_pkg::PH_CHK: chk_r <= full_word;
                    default: ph_r <= sbl_pkg::PH_SIZE;
                endcase
            end
        end
    end

    // otp word fetch for secure boot, reading up from row 0
    always_ff @(posedge clock) begin
        if (st_r == sbl_pkg::ST_HOLD) begin
            otp_ptr_r <= sbl_pkg::OTP_BOOT_ROW;
            ob_word_r <= '0;
            ob_cnt_r <= 2'd0;
        end else if (st_r == sbl_pkg::ST_OTPW) begin
            ob_word_r <= otp_rdata;
            ob_cnt_r <= 2'd0;
            otp_ptr_r <= otp_ptr_r + 12'd1;
        end else if (st_r == sbl_pkg::ST_OTPB) begin
            ob_word_r <= {8'h00, ob_word_r[31:8]};
            ob_cnt_r <= ob_cnt_r + 2'd1;
        end
    end

    // port strobes toward flash, otp and ram
    always_ff @(posedge clock) begin
        if (srst) begin
            flash_req_r <= 1'b0;
            otp_rd_r <= 1'b0;
            otp_raddr_r <= '0;
            ram_we_r <= 1'b0;
            ram_addr_r <= '0;
            ram_wdata_r <= '0;
        end else begin
            flash_req_r <= st_r == sbl_pkg::ST_REQ && !sec_r[sbl_pkg::SEC_BOOT_OTP];
            otp_rd_r <= st_r == sbl_pkg::ST_SEC || st_r == sbl_pkg::ST_OTPR;
            otp_raddr_r <= (st_r == sbl_pkg::ST_SEC) ? sbl_pkg::OTP_SEC_ROW : otp_ptr_r;
            ram_we_r <= word_done && ph_r == sbl_pkg::PH_PROG;
            ram_wdata_r <= full_word;
            if (st_r == sbl_pkg::ST_HOLD) begin
                ram_addr_r <= RAM_AW'(sbl_pkg::RAM_BASE);
            end else if (ram_we_r) begin
                ram_addr_r <= ram_addr_r + 1'b1;
            end
        end
    end

    // core control and security outputs; disables stay on until the word is loaded
    always_ff @(posedge clock) begin
        if (srst) begin
            core_rst_r <= 1'b1;
            core_run_r <= 1'b0;
            core_pc_r <= sbl_pkg::RAM_BASE;
            gpio_pd_en_r <= 1'b1;
            jtag_dis_r <= 1'b1;
            link_dis_r <= 1'b1;
            jtag_otp_dis_r <= 1'b1;
            otp_redund_en_r <= 1'b0;
            user_id_r <= '0;
        end else begin
            gpio_pd_en_r <= !ext_rst_n;
            // the pin must win over a running program, or the core leaves reset for one cycle
            core_rst_r <= st_r != sbl_pkg::ST_RUN || !ext_rst_n;
            core_run_r <= st_r == sbl_pkg::ST_RUN && ext_rst_n;
            core_pc_r <= sbl_pkg::RAM_BASE;
            jtag_dis_r <= !sec_valid_r || sec_r[sbl_pkg::SEC_JTAG_DIS];
            link_dis_r <= !sec_valid_r || sec_r[sbl_pkg::SEC_LINK_DIS];
            jtag_otp_dis_r <= !sec_valid_r || sec_r[sbl_pkg::SEC_JTAG_OTP];
            otp_redund_en_r <= sec_valid_r && sec_r[sbl_pkg::SEC_REDUND];
            user_id_r <= sec_r[sbl_pkg::SEC_UID_HI:sbl_pkg::SEC_UID_LO];
        end
    end

    // otp programming ports; a refused go sets a sticky flag, set beats clear
    always_ff @(posedge clock) begin
        if (srst) begin
            prg_addr_r <= '0;
            prg_data_r <= '0;
            refused_r <= 1'b0;
            otp_prog_r <= 1'b0;
            otp_paddr_r <= '0;
            otp_pdata_r <= '0;
        end else begin
            if (reg_we && reg_addr == sbl_pkg::REG_PRG_ADDR) prg_addr_r <= reg_wdata[15:0];
            if (reg_we && reg_addr == sbl_pkg::REG_PRG_DATA) prg_data_r <= reg_wdata;
            otp_prog_r <= go_wr && prg_ok;
            otp_paddr_r <= prg_addr_r[11:0];
            otp_pdata_r <= prg_data_r;
            if (go_wr && !prg_ok) begin
                refused_r <= 1'b1;
            end else if (reg_we && reg_addr == sbl_pkg::REG_PRG_CTRL && reg_wdata[sbl_pkg::CTRL_CLR]) begin
                refused_r <= 1'b0;
            end
        end
    end

    // register reads, data in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata_r <= '0;
        end else if (reg_re) begin
            case (reg_addr)
                sbl_pkg::REG_SEC: reg_rdata_r <= sec_r;
                sbl_pkg::REG_STATUS: reg_rdata_r <= {27'h000_0000, refused_r, st_r == sbl_pkg::ST_FAIL,
                    core_run_r, sec_r[sbl_pkg::SEC_BOOT_OTP], sec_valid_r};
                sbl_pkg::REG_PRG_ADDR: reg_rdata_r <= {16'h0000, prg_addr_r};
                sbl_pkg::REG_PRG_DATA: reg_rdata_r <= prg_data_r;
                sbl_pkg::REG_PRG_CTRL: reg_rdata_r <= {30'h0000_0000, refused_r, 1'b0};
                default: reg_rdata_r <= '0;
            endcase
        end else begin
            reg_rdata_r <= '0;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign flash_req = flash_req_r;
    assign otp_rd = otp_rd_r;
    assign otp_raddr = otp_raddr_r;
    assign otp_prog = otp_prog_r;
    assign otp_paddr = otp_paddr_r;
    assign otp_pdata = otp_pdata_r;
    assign ram_we = ram_we_r;
    assign ram_addr = ram_addr_r;
    assign ram_wdata = ram_wdata_r;
    assign core_rst = core_rst_r;
    assign core_run = core_run_r;
    assign core_pc = core_pc_r;
    assign gpio_pd_en = gpio_pd_en_r;
    assign jtag_dis = jtag_dis_r;
    assign link_dis = link_dis_r;
    assign jtag_otp_dis = jtag_otp_dis_r;
    assign otp_redund_en = otp_redund_en_r;
    assign user_id = user_id_r;

    pd_hold_a: assert property (@(posedge clock) disable iff (srst)
        !ext_rst_n |=> gpio_pd_en && core_rst && !core_run)
        else $error("pull-down or reset not held during pin reset");
    boot_delay_a: assert property (@(posedge clock) disable iff (srst)
        (st_r == sbl_pkg::ST_SEC) |-> $past(st_r == sbl_pkg::ST_DELAY) && $past(dly_r) == DLY_LAST)
        else $error("boot started before reset delay");
    sec_first_a: assert property (@(posedge clock) disable iff (srst)
        (flash_req || ram_we || (otp_rd && otp_raddr != sbl_pkg::OTP_SEC_ROW)) |-> sec_valid_r)
        else $error("boot access before security word loaded");
    src_sel_a: assert property (@(posedge clock) disable iff (srst)
        (flash_req |-> !sec_r[sbl_pkg::SEC_BOOT_OTP]) and
        ((otp_rd && sec_valid_r) |-> sec_r[sbl_pkg::SEC_BOOT_OTP]))
        else $error("wrong boot source");
    prog_lock_a: assert property (@(posedge clock) disable iff (srst || !ext_rst_n)
        otp_prog |-> $past(sec_valid_r) && !$past(sec_r[sbl_pkg::SEC_MASTER]) &&
        (otp_paddr == sbl_pkg::OTP_SEC_ROW || !$past(sec_r[sbl_pkg::SEC_LOCK0 + int'(otp_paddr[10:9])])))
        else $error("otp programmed through a lock");
    sec_out_a: assert property (@(posedge clock) disable iff (srst)
        !sec_valid_r |=> jtag_dis && link_dis && jtag_otp_dis && !otp_redund_en)
        else $error("security disables released before load");
    run_check_a: assert property (@(posedge clock) disable iff (srst)
        $rose(core_run) |-> (chk_r == sbl_pkg::SKIP_CRC || chk_r == ~crc_r) && core_pc == sbl_pkg::RAM_BASE)
        else $error("program started without a valid check");
    ram_order_a: assert property (@(posedge clock) disable iff (srst)
        ram_we |-> 32'(ram_addr) == size_r - rem_r - 32'd1)
        else $error("ram written out of order");
    word_lsb_a: assert property (@(posedge clock) disable iff (srst || !ext_rst_n)
        (word_done && ph_r == sbl_pkg::PH_SIZE) |=> size_r[31:24] == $past(cur_byte) &&
        size_r[23:0] == $past(word_sh_r[31:8]))
        else $error("word count not assembled lsb first");
endmodule

/* sbl_partner.sv */
// model of the boot flash byte reader and the otp array beside the loader
// assumes the bench loads img and mem by hierarchical reference before a boot
`timescale 1ns/1ns
module sbl_partner (
    input wire logic clock,
    input wire logic flash_req,
    output logic flash_valid,
    output logic [7:0] flash_byte,
    input wire logic otp_rd,
    input wire logic [11:0] otp_raddr,
    output logic [31:0] otp_rdata,
    input wire logic otp_prog,
    input wire logic [11:0] otp_paddr,
    input wire logic [31:0] otp_pdata
);
    logic [31:0] mem [0:4095]; // whole 12-bit row space: four sectors of 512 rows, the security row and unused rows
    logic [7:0] img [$];
    int wait_r = 0;
    logic [31:0] idle_r = 32'h0000_0000;
    int seed = 32'h1e2d7ec2;
    initial begin
        flash_valid = 1'b0;
        flash_byte = 8'h00;
    end
    // flash: one outstanding request, answered after one to four cycles
    always @(posedge clock) begin
        if (wait_r == 1 && img.size() > 0) begin
            flash_valid <= 1'b1;
            flash_byte <= img.pop_front();
            wait_r <= 0;
        end else begin
            flash_valid <= 1'b0;
            flash_byte <= ~flash_byte; // no byte is held once the strobe is gone
            if (flash_req) begin
                wait_r <= 1 + ($random(seed) & 3);
            end else if (wait_r > 1) begin
                wait_r <= wait_r - 1;
            end
        end
    end
    // otp: the loader takes the row at the edge that ends its read strobe
    assign otp_rdata = otp_rd ? mem[otp_raddr] : idle_r;
    always @(posedge clock) begin
        idle_r <= ~idle_r; // moving pattern while no row is read
        if (otp_prog) begin
            mem[otp_paddr] <= otp_pdata; // programming lands in the array
        end
    end
endmodule

/* test_secure_boot_otp_loader.sv */
// self-checking bench: boots from flash and otp, programs otp, checks locks
// assumes sbl_pkg and sbl_loader compiled first
`timescale 1ns/1ns
module test_secure_boot_otp_loader;
    logic clock, srst, ext_rst_n, reg_we, reg_re, flash_req, flash_valid, otp_rd, otp_prog, ram_we;
    logic core_rst, core_run, gpio_pd_en, jtag_dis, link_dis, jtag_otp_dis, otp_redund_en;
    logic [23:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, otp_rdata, otp_pdata, ram_wdata, core_pc;
    logic [7:0] flash_byte;
    logic [11:0] otp_raddr, otp_paddr;
    logic [15:0] ram_addr;
    logic [9:0] user_id;
    logic [47:0] q_ram [$], q_rd [$], q_prg [$];
    int n_mismatch = 0, compares = 0, cyc = 0, seed = 32'h1e2d7ec2;
    logic rd_pend = 1'b0;
    sbl_loader dut (.clock(clock), .srst(srst), .ext_rst_n(ext_rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .flash_req(flash_req), .flash_valid(flash_valid), .flash_byte(flash_byte), .otp_rd(otp_rd),
        .otp_raddr(otp_raddr), .otp_rdata(otp_rdata), .otp_prog(otp_prog), .otp_paddr(otp_paddr),
        .otp_pdata(otp_pdata), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .core_rst(core_rst), .core_run(core_run), .core_pc(core_pc), .gpio_pd_en(gpio_pd_en),
        .jtag_dis(jtag_dis), .link_dis(link_dis), .jtag_otp_dis(jtag_otp_dis),
        .otp_redund_en(otp_redund_en), .user_id(user_id));
    sbl_partner far (.clock(clock), .flash_req(flash_req), .flash_valid(flash_valid),
        .flash_byte(flash_byte), .otp_rd(otp_rd), .otp_raddr(otp_raddr), .otp_rdata(otp_rdata),
        .otp_prog(otp_prog), .otp_paddr(otp_paddr), .otp_pdata(otp_pdata));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic give_verdict;
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(string nm, logic [47:0] e, logic [47:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // strobes drop with a one-cycle gap so no signal is assigned twice in a step
    task automatic wr(logic [23:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clock);
        reg_we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(logic [23:0] a, logic [31:0] e);
        q_rd.push_back({16'h0000, e});
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clock);
        reg_re <= 1'b0;
        @(posedge clock);
    endtask
    task automatic prg(logic [15:0] a, logic [31:0] d, logic ok);
        wr(sbl_pkg::REG_PRG_ADDR, {16'h0000, a});
        wr(sbl_pkg::REG_PRG_DATA, d);
        if (ok) q_prg.push_back({4'h0, a[11:0], d});
        wr(sbl_pkg::REG_PRG_CTRL, 32'h0000_0001);
        rd(sbl_pkg::REG_PRG_CTRL, ok ? 32'h0000_0000 : 32'h0000_0002);
        wr(sbl_pkg::REG_PRG_CTRL, 32'h0000_0002);
    endtask
    // mode 0 good crc, 1 skip word, 2 wrong crc; otp marks an otp boot (no flash image loaded), the source itself is chosen by sec bit 5
    task automatic boot(logic [31:0] sec, int s, int mode, logic otp);
        logic [31:0] w, crc;
        logic [7:0] b [$];
        int t;
        crc = sbl_pkg::CRC_INIT;
        far.mem[12'h800] = sec;
        for (int i = 0; i <= s; i++) begin
            w = (i == 0) ? s : $random(seed);
            far.mem[i] = w;
            if (i > 0) q_ram.push_back({16'(i - 1), w});
            for (int k = 0; k < 8 * 4; k++) begin
                if (k % 8 == 0) b.push_back(w[k +: 8]); // least significant byte first
                crc = (crc[0] ^ w[k]) ? (crc >> 1) ^ sbl_pkg::CRC_POLY : crc >> 1;
            end
        end
        w = (mode == 1) ? sbl_pkg::SKIP_CRC : (mode == 0) ? ~crc : ~crc ^ 32'h0000_0001;
        far.mem[s + 1] = w;
        for (int k = 0; k < 4; k++) b.push_back(w[8 * k +: 8]);
        ext_rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        far.wait_r = 0;
        @(negedge clock);
        cmp("held", 3'b101, {gpio_pd_en, core_run, core_rst});
        @(posedge clock);
        ext_rst_n <= 1'b1;
        if (!otp) far.img = b;
        for (t = 0; t < 1600 && otp_rd !== 1'b1; t++) @(negedge clock);
        cmp("delay", 1, t >= 1500 && t < 1510);
        for (t = 0; t < 600 && core_run !== 1'b1; t++) @(negedge clock);
        cmp("run", {mode != 2, mode == 2, 32'h0000_0000}, {core_run, core_rst, core_pc});
        cmp("dis", {sec[13], sec[7], sec[1:0]}, {jtag_otp_dis, otp_redund_en, link_dis, jtag_dis});
        cmp("uid", sec[31:22], user_id);
        @(posedge clock);
        rd(sbl_pkg::REG_STATUS, {mode == 2, mode != 2, otp, 1'b1});
        rd(sbl_pkg::REG_SEC, sec);
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    always @(negedge clock) begin
        if (ram_we) cmp("ram", q_ram.size() > 0 ? q_ram.pop_front() : 48'hx, {ram_addr, ram_wdata});
        if (otp_prog) cmp("prog", q_prg.size() > 0 ? q_prg.pop_front() : 48'hx, {otp_paddr, otp_pdata});
        if (rd_pend) cmp("rdata", q_rd.size() > 0 ? q_rd.pop_front() : 48'hx, reg_rdata);
        rd_pend = reg_re;
    end
    initial begin
        {srst, ext_rst_n, reg_we, reg_re, reg_addr, reg_wdata} = {2'b11, 58'h0};
        far.mem[12'h800] = 32'h0000_0000;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        cmp("rst", 4'hf, {core_rst, gpio_pd_en, jtag_dis, link_dis});
        @(posedge clock);
        rd(24'h00_0010, 32'h0000_0000);
        boot(32'hA940_0281, 3, 0, 1'b0);
        wr(sbl_pkg::REG_SEC, 32'hFFFF_FFFF);
        rd(sbl_pkg::REG_SEC, 32'hA97F_8281);
        prg(16'h0010, $random(seed), 1'b1);
        prg(16'h0210, $random(seed), 1'b0);
        prg(16'h0900, $random(seed), 1'b0);
        prg(16'h0800, 32'h0000_0001, 1'b1);
        boot(32'h0000_3002, 0, 1, 1'b0);
        prg(16'h0010, $random(seed), 1'b0);
        boot(32'h0000_0020, 2, 1, 1'b1);
        boot(32'h0000_0000, 2, 2, 1'b0);
        repeat (2) @(posedge clock);
        cmp("left", 48'h0, 48'(q_ram.size() + q_prg.size() + q_rd.size()));
        give_verdict();
    end
endmodule
